// >>> hdl/ddis_sequencer.sv
// Interlock and sequencing logic for a cartridge disk drive: spindle enable,
// brush cycle, retract latch, cartridge unlock, servo release and ready.
// Assumes pins are asynchronous to pclk; APB master on the same clock.
// Summary of operation
// - Run mode, clamps closed, no emergency or reset: both phase enables on.
// - Revolution counter held cleared while in run mode.
// - In load, sixth index pulse clears run flip-flop and drops phase two.
// - Speed not ok when run drops: clear run flip-flop at once.
// - Phase one stays on while braking, off once spindle halted.
// - Open cartridge clamps inhibit spindle drive.
// - Emergency retract or power-on reset forces spindle drive off.
// - Emergency in run clears run flip-flop; it sets again afterwards.
// - Load with brushes home: latches set, no cycle; run starts brush enable.
// - Brushes out reset switch and cycle latches; enable holds till home.
// - Brushes home set switch latch; cycle latch set again on run to load.
// - Power-on reset clears the brush cycle latch.
// - Home high when retracted; over-tracks shows heads over media.
// - Retract latch set on brushes out, speed bad, or detector fault.
// - Retract latch clears on home only with brush home and speed ok.
// - Retract active drives heads home; inactive lets them advance.
// - Unlock only with phase one off, brushes home and heads home.
// - Servo release while heads home and retract asserted.
// - Ready when heads out of home and no write check; lamp follows.
// - Drive-ok-selected only while ready and controller selects drive.
// - Selected index used internally without ready gating.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ddis_sequencer
  import ddis_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // Drive pins
  input  wire logic        load_switch_n,
  input  wire logic        cartridge_clamps_closed,
  input  wire logic        emergency_head_pull_n_alt,
  input  wire logic        spindle_halted_n,
  input  wire logic        speed_ok,
  input  wire logic        brush_home,
  input  wire logic        head_home,
  input  wire logic        heads_over_media_sense,
  input  wire logic        selected_index,
  input  wire logic        drive_select,
  // Drive outputs
  output ddis_drive_t      drive_out
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  ddis_sense_t raw;
  ddis_sense_t sn;

  always_comb
  begin
    raw.run_sel                   = load_switch_n;
    raw.cartridge_clamps_closed   = cartridge_clamps_closed;
    raw.emergency_head_pull_n_alt = emergency_head_pull_n_alt;
    raw.spindle_halted_n          = spindle_halted_n;
    raw.speed_ok                  = speed_ok;
    raw.brush_home                = brush_home;
    raw.head_home                 = head_home;
    raw.heads_over_media_sense    = heads_over_media_sense;
    raw.selected_index            = selected_index;
    raw.drive_select              = drive_select;
  end

  // Sync stages reset to idle pin levels: a zero brush home or emergency
  // level would fake a brush or emergency event in the first two cycles after reset
  localparam ddis_sense_t SENSE_IDLE = '{
    run_sel:                   1'b0,
    cartridge_clamps_closed:   1'b0,
    emergency_head_pull_n_alt: 1'b1,
    spindle_halted_n:          1'b0,
    speed_ok:                  1'b0,
    brush_home:                1'b1,
    head_home:                 1'b1,
    heads_over_media_sense:    1'b0,
    selected_index:            1'b0,
    drive_select:              1'b0
  };

  ddis_sync #(.WIDTH($bits(ddis_sense_t)), .RESET_VAL(SENSE_IDLE)) u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw),
    .sync_out (sn)
  );

  // ****************************************************************
  // Shared decodes
  // ****************************************************************
  // Phase enables and the spindle state machine ask the same question
  function automatic logic drive_allowed
  (
    input logic run,
    input logic clamps,
    input logic emg
  );
    return run && clamps && !emg;
  endfunction : drive_allowed

  // One register decode serves the error and write paths; reads decode paddr in a case
  function automatic logic addr_hit
  (
    input logic [11:0] addr,
    input logic [11:0] reg_addr
  );
    return addr == reg_addr;
  endfunction : addr_hit

  // ****************************************************************
  // Software control and edge detection
  // ****************************************************************
  logic [31:0] ctrl_q;
  logic        index_d1_q;
  logic        run_d1_q;
  logic        index_pulse;
  logic        run_to_load;
  logic        emerg;
  logic        force_ret;
  logic        write_check;

  assign emerg       = !sn.emergency_head_pull_n_alt;
  assign force_ret   = ctrl_q[CTRL_FORCE_RET];
  assign write_check = ctrl_q[CTRL_WR_CHECK];
  assign index_pulse = sn.selected_index && !index_d1_q;
  assign run_to_load = run_d1_q && !sn.run_sel;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      index_d1_q <= 1'b0;
      run_d1_q   <= 1'b0;
    end
    else
    begin
      index_d1_q <= sn.selected_index;
      run_d1_q   <= sn.run_sel;
    end
  end

  // ****************************************************************
  // Spindle run flip-flop and revolution counter
  // ****************************************************************
  logic [2:0] rev_q;
  logic       spin_run_q;
  ddis_spin_t spin_q;

  // Counter idles at clear in run so a stop with speed ok waits a full six turns
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rev_q <= REV_CNT_CLEAR;
    else if (sn.run_sel)
      rev_q <= REV_CNT_CLEAR;
    else if (index_pulse && rev_q != STOP_REVS)
      rev_q <= rev_q + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spin_run_q <= 1'b0;
    else if (sn.run_sel && emerg)
      spin_run_q <= 1'b0;
    else if (sn.run_sel)
      spin_run_q <= 1'b1;
    else if (run_d1_q && !sn.speed_ok)
      spin_run_q <= 1'b0;
    else if (index_pulse && rev_q == STOP_REVS - 3'h1)
      spin_run_q <= 1'b0;
  end

  // Spindle state tracks drive vs braking for phase one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spin_q <= SPN_STOPPED;
    else
    begin
      case (spin_q)
        SPN_STOPPED:
          if (drive_allowed(spin_run_q, sn.cartridge_clamps_closed, emerg))
            spin_q <= SPN_RUNNING;
        SPN_RUNNING:
          if (!drive_allowed(spin_run_q, sn.cartridge_clamps_closed, emerg))
            spin_q <= SPN_COASTING;
        SPN_COASTING:
          if (drive_allowed(spin_run_q, sn.cartridge_clamps_closed, emerg))
            spin_q <= SPN_RUNNING;
          else if (!sn.spindle_halted_n)
            spin_q <= SPN_STOPPED;
        default:
          spin_q <= SPN_STOPPED;
      endcase
    end
  end

  // ****************************************************************
  // Brush latches
  // ****************************************************************
  logic brush_sw_q;
  logic brush_cyc_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brush_sw_q <= 1'b1;
    else if (!sn.brush_home)
      brush_sw_q <= 1'b0;
    else
      brush_sw_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brush_cyc_q <= 1'b0;
    else if (!brush_sw_q)
      brush_cyc_q <= 1'b0;
    else if (run_to_load || (!sn.run_sel && sn.brush_home))
      brush_cyc_q <= 1'b1;
  end

  // ****************************************************************
  // Retract latch
  // ****************************************************************
  logic retract_q;
  logic detector_fault;
  logic retract_set;

  // Heads over media yet reading home means one detector is lying
  assign detector_fault = sn.head_home && sn.heads_over_media_sense;
  assign retract_set    = !sn.brush_home || !sn.speed_ok || detector_fault
                          || emerg || force_ret;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      retract_q <= 1'b1;
    else if (retract_set)
      retract_q <= 1'b1;
    else if (sn.head_home)
      retract_q <= 1'b0;
  end

  // ****************************************************************
  // Output register
  // ****************************************************************
  ddis_drive_t drv_d;
  logic        p1_on;
  logic        p2_on;

  always_comb
  begin
    p2_on = drive_allowed(spin_run_q, sn.cartridge_clamps_closed, emerg);
    // Running state covers the cycle before coasting so phase one never blips off
    p1_on = (p2_on || spin_q == SPN_RUNNING || spin_q == SPN_COASTING)
            && sn.cartridge_clamps_closed
            && !emerg;
    drv_d.phase1_en_n         = !p1_on;
    drv_d.phase2_en_n         = !p2_on;
    drv_d.brush_enable        = (brush_cyc_q && sn.run_sel) || !brush_sw_q;
    drv_d.retract_n           = !retract_q;
    drv_d.cartridge_release_n = !(!p1_on && sn.brush_home && sn.head_home);
    drv_d.servo_release       = sn.head_home && retract_q;
    drv_d.ready               = !sn.head_home && !write_check;
    drv_d.drive_ok_lamp_n     = !drv_d.ready;
    drv_d.drive_ok_selected   = drv_d.ready && sn.drive_select;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_out                     <= '0;
      drive_out.phase1_en_n         <= 1'b1;
      drive_out.phase2_en_n         <= 1'b1;
      drive_out.retract_n           <= 1'b0;
      drive_out.cartridge_release_n <= 1'b1;
      drive_out.drive_ok_lamp_n     <= 1'b1;
    end
    else
      drive_out <= drv_d;
  end

  // ****************************************************************
  // APB slave: zero wait states, unmapped reads zero with error
  // ****************************************************************
  logic                    apb_acc;
  logic                    hit;
  logic [STATUS_WIDTH-1:0] status;

  assign apb_acc = psel && penable;
  assign hit     = addr_hit(paddr, ADDR_CTRL) || addr_hit(paddr, ADDR_STATUS);
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !hit;
  assign status  = {rev_q, spin_q == SPN_COASTING, retract_q, brush_cyc_q, brush_sw_q,
                    spin_run_q, drive_out.ready, drive_out.drive_ok_selected,
                    !drive_out.phase1_en_n, !drive_out.phase2_en_n, drive_out.servo_release,
                    !drive_out.cartridge_release_n};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= CTRL_RESET;
    else if (apb_acc && pwrite && addr_hit(paddr, ADDR_CTRL))
      ctrl_q <= pwdata & 32'h0000_0003;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        ADDR_CTRL:   prdata <= ctrl_q;
        ADDR_STATUS: prdata <= {{(32-STATUS_WIDTH){1'b0}}, status};
        default:     prdata <= '0;
      endcase
    end
  end

endmodule : ddis_sequencer
`default_nettype wire

// >>> hdl/ddis_pkg.sv
// Package for the cartridge drive interlock sequencer: constants and carriers.
// Assumes a single 10 MHz system clock; no register bus traffic is decoded here.
package ddis_pkg;

  // ****************************************************************
  // Timing and counts
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam logic [2:0]  STOP_REVS       = 3'h6;
  localparam logic [2:0]  REV_CNT_CLEAR   = 3'h0;
  localparam int unsigned SYNC_STAGES     = 2;

  // ****************************************************************
  // APB register map
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam int unsigned CTRL_FORCE_RET  = 0;
  localparam int unsigned CTRL_WR_CHECK   = 1;
  localparam int unsigned STATUS_WIDTH    = 14;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic run_sel;          // Load/run switch in run (load_switch_n high)
    logic cartridge_clamps_closed;
    logic emergency_head_pull_n_alt;
    logic spindle_halted_n;
    logic speed_ok;
    logic brush_home;
    logic head_home;
    logic heads_over_media_sense;
    logic selected_index;
    logic drive_select;
  } ddis_sense_t;

  typedef struct packed {
    logic phase1_en_n;
    logic phase2_en_n;
    logic brush_enable;
    logic retract_n;
    logic cartridge_release_n;
    logic servo_release;
    logic ready;
    logic drive_ok_lamp_n;
    logic drive_ok_selected;
  } ddis_drive_t;

  typedef enum logic [1:0] {
    SPN_STOPPED,
    SPN_RUNNING,
    SPN_COASTING
  } ddis_spin_t;

endpackage : ddis_pkg

// >>> hdl/ddis_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous levels.
// Assumes inputs come from switches, sensors or another clock domain.
`timescale 1ns/1ns
`default_nettype none
module ddis_sync
  import ddis_pkg::*;
#(
  parameter int unsigned    WIDTH     = 10,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : ddis_sync
`default_nettype wire

// >>> tb/ddis_seq_sva.sv
// Checker for the interlock sequencer outputs against its pin inputs.
// Assumes outputs lag pins by three edges and run flip-flop effects by four.
`timescale 1ns/1ns
`default_nettype none
module ddis_seq_sva
  import ddis_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Pins
  input wire logic        load_switch_n,
  input wire logic        cartridge_clamps_closed,
  input wire logic        emergency_head_pull_n_alt,
  input wire logic        spindle_halted_n,
  input wire logic        brush_home,
  input wire logic        head_home,
  input wire logic        drive_select,
  // Outputs
  input wire ddis_drive_t drive_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Held inputs outlast the sync and run flip-flop latency
  sequence run_held;
    (load_switch_n && cartridge_clamps_closed && emergency_head_pull_n_alt)[*6];
  endsequence
  sequence halted_in_load;
    (!load_switch_n && !spindle_halted_n)[*5];
  endsequence

  run_drive_a: assert property (run_held |-> !drive_out.phase1_en_n && !drive_out.phase2_en_n)
    else $error("spindle not driven in run");
  clamp_inhibit_a: assert property (!cartridge_clamps_closed[*5] |-> drive_out.phase2_en_n)
    else $error("drive with clamps open");
  emerg_off_a: assert property (!emergency_head_pull_n_alt[*5] |->
    drive_out.phase2_en_n && !drive_out.retract_n)
    else $error("drive on during emergency");
  brake_off_a: assert property (halted_in_load |-> drive_out.phase1_en_n)
    else $error("phase one on after halt");
  unlock_gate_a: assert property (!drive_out.cartridge_release_n |->
    drive_out.phase1_en_n && $past(brush_home, 3) && $past(head_home, 3))
    else $error("unlock without interlocks");
  servo_gate_a: assert property (drive_out.servo_release |->
    !drive_out.retract_n && $past(head_home, 3))
    else $error("servo release without cause");
  ready_home_a: assert property (drive_out.ready |-> !$past(head_home, 3))
    else $error("ready with heads home");
  lamp_follow_a: assert property (drive_out.drive_ok_lamp_n != drive_out.ready)
    else $error("lamp disagrees with ready");
  drive_ok_selected_a: assert property (drive_out.drive_ok_selected |->
    drive_out.ready && $past(drive_select, 3))
    else $error("drive_ok_selected without select");
endmodule : ddis_seq_sva

bind ddis_sequencer ddis_seq_sva u_sva (
  .pclk(pclk), .presetn(presetn), .load_switch_n(load_switch_n),
  .cartridge_clamps_closed(cartridge_clamps_closed),
  .emergency_head_pull_n_alt(emergency_head_pull_n_alt),
  .spindle_halted_n(spindle_halted_n), .brush_home(brush_home), .head_home(head_home),
  .drive_select(drive_select), .drive_out(drive_out));
`default_nettype wire

// >>> tb/ddis_ctl_model.sv
// Controller model: raises the drive select a chosen number of cycles after asked.
// Assumes the bench sets the lag; a lag of zero answers promptly.
`timescale 1ns/1ns
`default_nettype none
module ddis_ctl_model
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench side
  input  wire logic       want,
  input  wire logic [3:0] lag,
  // Drive side
  output var  logic       drive_select
);
  logic [3:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q        <= 4'h0;
      drive_select <= 1'b0;
    end
    else
    begin
      cnt_q        <= (want && cnt_q < lag) ? cnt_q + 4'h1 : (want ? cnt_q : 4'h0);
      drive_select <= want && cnt_q >= lag;
    end
  end
endmodule : ddis_ctl_model
`default_nettype wire

// >>> tb/tb.sv
// Bench for the interlock sequencer: pin scenarios, APB access, controller model.
// Assumes the 10 MHz clock and the three-edge pin latency of the design.
`timescale 1ns/1ns
`default_nettype none
module tb
  import ddis_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        lsw_n = 1'b0, clamp = 1'b1, emg_n = 1'b1, halt_n = 1'b0, spd = 1'b1;
  logic        bhome = 1'b1, hhome = 1'b1, over = 1'b0, idx = 1'b0, want = 1'b0;
  logic        pready, pslverr, dsel, er;
  logic [3:0]  lag = 4'h2;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0000_0EAF;
  ddis_drive_t drv;
  int          n_mismatch = 0;
  int          total_checks = 0;

  always #50 pclk = ~pclk;

  ddis_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .load_switch_n(lsw_n), .cartridge_clamps_closed(clamp),
    .emergency_head_pull_n_alt(emg_n), .spindle_halted_n(halt_n), .speed_ok(spd),
    .brush_home(bhome), .head_home(hhome), .heads_over_media_sense(over),
    .selected_index(idx), .drive_select(dsel), .drive_out(drv));
  ddis_ctl_model ctl (.pclk(pclk), .presetn(presetn), .want(want), .lag(lag),
    .drive_select(dsel));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic fr_exp(input logic rdy, input logic sel);
    return rdy & sel;
  endfunction : fr_exp

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    do cyc(1); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(1);
  endtask : apb
  // Pulses last three clocks: long enough for sync plus edge detect
  task automatic pulse(input int n);
    repeat (n)
    begin
      idx <= 1'b1;
      cyc(3);
      idx <= 1'b0;
      cyc(3);
    end
  endtask : pulse

  initial
  begin
    cyc(5000);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    cyc(12);
    chk("reset_out", 32'h0000_0192, drv);
    presetn <= 1'b1;
    cyc(8);
    chk("unlock", 0, drv.cartridge_release_n);
    chk("brush_idle", 0, drv.brush_enable);
    lsw_n <= 1'b1; halt_n <= 1'b1;
    cyc(8);
    chk("ph1_run", 0, drv.phase1_en_n);
    chk("ph2_run", 0, drv.phase2_en_n);
    chk("brush_go", 1, drv.brush_enable);
    bhome <= 1'b0;
    cyc(6);
    chk("brush_out", 1, drv.brush_enable);
    chk("retract_brush", 0, drv.retract_n);
    bhome <= 1'b1;
    cyc(6);
    chk("brush_done", 0, drv.brush_enable);
    $display("test spindle_run done");
    pulse(3);
    lsw_n <= 1'b0;
    pulse(5);
    cyc(6);
    chk("ph2_fifth", 0, drv.phase2_en_n);
    pulse(1);
    cyc(6);
    chk("ph2_sixth", 1, drv.phase2_en_n);
    chk("ph1_brake", 0, drv.phase1_en_n);
    halt_n <= 1'b0;
    cyc(6);
    chk("ph1_halt", 1, drv.phase1_en_n);
    $display("test stop_delay done");
    lsw_n <= 1'b1; halt_n <= 1'b1; spd <= 1'b0;
    cyc(8);
    lsw_n <= 1'b0;
    cyc(6);
    chk("skip", 1, drv.phase2_en_n);
    spd <= 1'b1; lsw_n <= 1'b1;
    cyc(8);
    emg_n <= 1'b0;
    cyc(6);
    chk("emerg", 1, drv.phase2_en_n);
    emg_n <= 1'b1;
    cyc(8);
    chk("emerg_end", 0, drv.phase2_en_n);
    clamp <= 1'b0;
    cyc(6);
    chk("clamp", 1, drv.phase2_en_n);
    clamp <= 1'b1; hhome <= 1'b0; over <= 1'b1;
    cyc(8);
    $display("test interlocks done");
    repeat (8)
    begin
      seed = xs(seed);
      want <= seed[0];
      lag <= seed[4:1] & 4'h7;
      cyc(14);
      chk("ready", 1, drv.ready);
      chk("lamp", 0, drv.drive_ok_lamp_n);
      chk("drive_ok_selected", fr_exp(1'b1, want), drv.drive_ok_selected);
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    cyc(6);
    chk("wr_check", 0, drv.ready);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("st_ready", 0, rd[5]);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_err", 1, er);
    chk("unmapped_rd", 0, rd);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    hhome <= 1'b1; over <= 1'b0;
    cyc(6);
    chk("force_ret", 0, drv.retract_n);
    chk("servo", 1, drv.servo_release);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("st_retract", 1, rd[9]);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    over <= 1'b1;
    cyc(6);
    chk("det_fault", 0, drv.retract_n);
    $display("test apb done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
